// >>> verilog/occ_regs.svh
`ifndef OCC_REGS_SVH
`define OCC_REGS_SVH
`define OCC_ADDR_W 4
`define OCC_CTRL_OFS 4'h0
`define OCC_PRI_OFS 4'h4
`define OCC_SEC_OFS 4'h8
`define OCC_STAT_OFS 4'hC
`define OCC_ON_BIT 15
`define OCC_IDLE_STOP_BIT_BIT 13
`define OCC_W32_BIT 5
`define OCC_FLT_BIT 4
`define OCC_TSEL_BIT 3
`define OCC_CTRL_RESET 32'h0000_0000
`define OCC_CTRL_WMASK 32'h0000_A02F
`endif

// >>> verilog/occ_pkg.sv
package occ_pkg;
	typedef enum logic [2:0] {
		OCC_M_OFF = 3'h0,
		OCC_M_SET = 3'h1,
		OCC_M_CLR = 3'h2,
		OCC_M_TGL = 3'h3,
		OCC_M_ONE = 3'h4,
		OCC_M_CONT = 3'h5,
		OCC_M_PWM = 3'h6,
		OCC_M_PWMF = 3'h7
	} occ_mode_e;
endpackage

// >>> verilog/occ_output_compare.sv
// Chosen here: the address map and the strobed register port.
`include "occ_regs.svh"
module occ_output_compare
	import occ_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [`OCC_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [15:0] timer2_count,
	input wire logic [15:0] timer3_count,
	input wire logic [31:0] timer_pair_count,
	input wire logic cpu_idle,
	input wire logic fault_pin,
	output logic compare_output_pin,
	output logic compare_irq
);

	logic [31:0] ctrl;
	logic [31:0] primary_compare_value;
	logic [31:0] secondary_compare_value;
	logic [31:0] duty_active;
	logic pwm_fault_flag;
	logic fault_s1;
	logic fault_s2;
	logic [31:0] timer_now;
	logic [31:0] timer_prev;
	logic match_pri;
	logic match_sec;
	logic period_start;
	logic run;
	logic one_done;
	logic mode_wr;
	logic next_pin;
	occ_mode_e mode;

	function automatic logic cmp_eq(input logic [31:0] a, input logic [31:0] b, input logic w);
		cmp_eq = w ? (a == b) : (a[15:0] == b[15:0]);
	endfunction

	assign mode = occ_mode_e'(ctrl[2:0]);
	assign mode_wr = reg_wr && (reg_addr == `OCC_CTRL_OFS);
	// 32-bit pair or one of two 16-bit timers
	assign timer_now = ctrl[`OCC_W32_BIT] ? timer_pair_count :
		{16'h0000, ctrl[`OCC_TSEL_BIT] ? timer3_count : timer2_count};
	assign run = ctrl[`OCC_ON_BIT] && !(ctrl[`OCC_IDLE_STOP_BIT_BIT] && cpu_idle);
	assign match_pri = run && cmp_eq(timer_now, primary_compare_value, ctrl[`OCC_W32_BIT]);
	assign match_sec = run && cmp_eq(timer_now, secondary_compare_value, ctrl[`OCC_W32_BIT]);
	// timer wrapped or restarted: new period
	assign period_start = run && (ctrl[`OCC_W32_BIT] ? (timer_now < timer_prev)
		: (timer_now[15:0] < timer_prev[15:0]));

	// fault pin synchroniser
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fault_s1 <= 1'b0;
			fault_s2 <= 1'b0;
		end else begin
			fault_s1 <= fault_pin;
			fault_s2 <= fault_s1;
		end
	end

	// control register
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= `OCC_CTRL_RESET;
		end else if (mode_wr) begin
			ctrl <= reg_wdata & `OCC_CTRL_WMASK;
		end
	end

	// compare values
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			primary_compare_value <= 32'h0000_0000;
			secondary_compare_value <= 32'h0000_0000;
		end else if (reg_wr) begin
			if (reg_addr == `OCC_PRI_OFS) begin
				primary_compare_value <= reg_wdata;
			end
			if (reg_addr == `OCC_SEC_OFS) begin
				secondary_compare_value <= reg_wdata;
			end
		end
	end

	// timer history for period detection
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			timer_prev <= 32'h0000_0000;
		end else begin
			timer_prev <= timer_now;
		end
	end

	// pwm duty shadow
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			duty_active <= 32'h0000_0000;
		end else if (mode_wr || !run) begin
			duty_active <= secondary_compare_value;
		end else if (period_start) begin
			duty_active <= secondary_compare_value;
		end
	end

	// fault flag: hardware set, cleared on mode rewrite, set wins
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pwm_fault_flag <= 1'b0;
		end else if (run && mode == OCC_M_PWMF && fault_s2) begin
			pwm_fault_flag <= 1'b1;
		end else if (mode_wr) begin
			pwm_fault_flag <= 1'b0;
		end
	end

	// single pulse progress
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			one_done <= 1'b0;
		end else if (mode_wr || !ctrl[`OCC_ON_BIT]) begin
			one_done <= 1'b0;
		end else if (mode == OCC_M_ONE && match_sec && compare_output_pin) begin
			one_done <= 1'b1;
		end
	end

	// output next value per mode
	always_comb begin
		next_pin = compare_output_pin;
		if (mode_wr) begin
			next_pin = reg_wdata[`OCC_ON_BIT] && (reg_wdata[2:0] == OCC_M_CLR);
		end else if (!ctrl[`OCC_ON_BIT]) begin
			next_pin = 1'b0;
		end else if (run) begin
			case (mode)
				OCC_M_OFF: next_pin = 1'b0;
				OCC_M_SET: next_pin = match_pri ? 1'b1 : compare_output_pin;
				OCC_M_CLR: next_pin = match_pri ? 1'b0 : compare_output_pin;
				OCC_M_TGL: next_pin = match_pri ? !compare_output_pin : compare_output_pin;
				OCC_M_ONE: begin
					if (match_sec) begin
						next_pin = 1'b0;
					end else if (match_pri && !one_done) begin
						next_pin = 1'b1;
					end
				end
				OCC_M_CONT: begin
					if (match_sec) begin
						next_pin = 1'b0;
					end else if (match_pri) begin
						next_pin = 1'b1;
					end
				end
				OCC_M_PWM, OCC_M_PWMF: begin
					if (mode == OCC_M_PWMF && (pwm_fault_flag || fault_s2)) begin
						next_pin = 1'b0;
					end else if (period_start) begin
						next_pin = 1'b1;
					end else if (cmp_eq(timer_now, duty_active, ctrl[`OCC_W32_BIT])) begin
						next_pin = 1'b0;
					end
				end
				default: next_pin = compare_output_pin;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			compare_output_pin <= 1'b0;
		end else begin
			compare_output_pin <= next_pin;
		end
	end

	// interrupt pulse on compare event, or on period start (plus new fault in PWMF) in PWM modes
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			compare_irq <= 1'b0;
		end else begin
			case (mode)
				OCC_M_OFF: compare_irq <= 1'b0;
				OCC_M_ONE, OCC_M_CONT: compare_irq <= match_sec;
				OCC_M_PWM: compare_irq <= period_start;
				OCC_M_PWMF: compare_irq <= period_start || (fault_s2 && run && !pwm_fault_flag);
				default: compare_irq <= match_pri;
			endcase
		end
	end

	// register read, one cycle latency
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`OCC_CTRL_OFS: reg_rdata <= ctrl
					| ({31'h0000_0000, pwm_fault_flag && mode == OCC_M_PWMF} << `OCC_FLT_BIT);
				`OCC_PRI_OFS: reg_rdata <= primary_compare_value;
				`OCC_SEC_OFS: reg_rdata <= secondary_compare_value;
				`OCC_STAT_OFS: reg_rdata <= {30'h0000_0000, one_done, compare_output_pin};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule // occ_output_compare

// >>> dv/occ_output_compare_properties.sv
module occ_output_compare_properties(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [15:0] timer2_count,
	input wire logic [15:0] timer3_count,
	input wire logic [31:0] timer_pair_count,
	input wire logic cpu_idle,
	input wire logic fault_pin,
	input wire logic compare_output_pin,
	input wire logic compare_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] ctl, pri;
	logic [2:0] m;
	logic wc, run, hit, pin, irq;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) ctl <= 32'h0;
		else if (wc) ctl <= reg_wdata & 32'hA02F;
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) pri <= 32'h0;
		else if (reg_wr && reg_addr == 4'h4) pri <= reg_wdata;
	end
	assign wc = reg_wr && reg_addr == 4'h0;
	assign m = ctl[2:0];
	assign pin = compare_output_pin;
	assign irq = compare_irq;
	assign run = ctl[15] && !(ctl[13] && cpu_idle) && !wc;
	assign hit = ctl[5] ? timer_pair_count == pri
		: (ctl[3] ? timer3_count : timer2_count) == pri[15:0];
	property p_off; !ctl[15] && !wc |=> !pin && !irq; endproperty
	a_off: assert property (p_off) else $error("off");
	property p_idl; ctl[15] && ctl[13] && cpu_idle && !wc |=> $stable(pin) && !irq; endproperty
	a_idl: assert property (p_idl) else $error("idle");
	property p_nop; ctl[15] && m == 3'h0 && !wc |=> !pin && !irq; endproperty
	a_nop: assert property (p_nop) else $error("none");
	property p_set; run && m == 3'h1 && hit |=> pin && irq; endproperty
	a_set: assert property (p_set) else $error("set");
	property p_clr; run && m == 3'h2 && hit |=> !pin && irq; endproperty
	a_clr: assert property (p_clr) else $error("clr");
	property p_tgl; run && m == 3'h3 && hit |=> pin != $past(pin) && irq; endproperty
	a_tgl: assert property (p_tgl) else $error("tgl");
	property p_flt; (run && m == 3'h7 && fault_pin) [*4] |=> !pin; endproperty
	a_flt: assert property (p_flt) else $error("flt");
	property p_rdz; !reg_rd |=> reg_rdata == 32'h0; endproperty
	a_rdz: assert property (p_rdz) else $error("rdz");
endmodule // occ_output_compare_properties
bind occ_output_compare occ_output_compare_properties i_chk(.*);

// >>> dv/occ_timer_model.sv
module occ_timer_model(
	input wire logic core_clk,
	input wire logic rstn,
	output logic [15:0] timer2_count,
	output logic [15:0] timer3_count,
	output logic [31:0] timer_pair_count
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) {timer2_count, timer3_count, timer_pair_count} <= 64'h10000;
		else begin
			timer2_count <= (timer2_count + 16'h1) & 16'hF;
			timer3_count <= timer3_count == 16'hC ? 16'h0 : timer3_count + 16'h1;
			timer_pair_count <= timer_pair_count[4:0] == 5'h13 ? 32'h10000 : timer_pair_count + 32'h1;
		end
	end
endmodule // occ_timer_model

// >>> dv/occ_output_compare_tb.sv
module occ_output_compare_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, cpu_idle = 0, fault_pin = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, tp, hi, sh = 0, pr = 0;
	logic [15:0] t2, t3;
	logic pin, irq, ep = 0, ei = 0, chk = 0;
	int error_cnt = 0, n_checks = 0, cyc = 0, m, w, h, r, q;
	occ_timer_model i_tm(.core_clk, .rstn, .timer2_count(t2), .timer3_count(t3),
		.timer_pair_count(tp));
	occ_output_compare i_dut(.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .timer2_count(t2), .timer3_count(t3), .timer_pair_count(tp),
		.cpu_idle, .fault_pin, .compare_output_pin(pin), .compare_irq(irq));
	initial forever #2 core_clk = ~core_clk;
	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic ck(input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge core_clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge core_clk);
		reg_rd <= 0;
		@(negedge core_clk);
		ck(reg_rdata, e);
	endtask
	task automatic win;
		logic p;
		@(negedge core_clk);
		p = pin;
		{h, r, q} = 96'h0;
		repeat (48) begin
			@(negedge core_clk);
			h += pin;
			r += pin && !p;
			q += irq;
			p = pin;
		end
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			summarize;
		end
		if (chk) begin
			ck(pin, ep);
			ck(irq, ei);
		end
		hi = sh[5] ? tp : sh[3] ? t3 : t2;
		ei = sh[15] && !(sh[13] && cpu_idle) && hi == (sh[5] ? pr : pr[15:0]) && sh[1:0] != 0;
		if (ei) ep = sh[1:0] == 1 ? 1'b1 : sh[1:0] == 2 ? 1'b0 : !ep;
		if (reg_wr && reg_addr == 4'h0) begin
			sh = reg_wdata;
			ep = sh[15] && sh[2:0] == 2;
		end
		if (reg_wr && reg_addr == 4'h4) pr = reg_wdata;
	end
	initial begin
		void'($urandom(4726));
		repeat (10) @(posedge core_clk);
		rstn <= 1;
		rd(4'h0, 32'h0);
		rd(4'h2, 32'h0);
		wr(4'h0, 32'hFFFFFFFF);
		rd(4'h0, 32'hA02F);
		for (m = 1; m < 4; m++) begin
			w = $urandom % 2;
			wr(4'h0, 32'h0);
			wr(4'h4, {w ? 16'h1 : 16'($urandom), 16'($urandom % 12)});
			wr(4'h0, 32'h8000 | w << 5 | ($urandom % 2) << 3 | ($urandom % 2) << 13 | m);
			chk = 1;
			repeat (60) @(posedge core_clk) cpu_idle <= $urandom % 2;
			chk = 0;
			cpu_idle <= 0;
		end
		wr(4'h0, 32'h0);
		wr(4'h8, 32'h9);
		wr(4'h4, 32'h3);
		wr(4'h0, 32'h8004);
		win;
		ck(r, 1);
		wr(4'h0, 32'h0);
		wr(4'h0, 32'h8005);
		win;
		ck(r, 3);
		ck(q, 3);
		wr(4'h8, 32'h5);
		fault_pin <= 1;
		wr(4'h0, 32'h8016);
		rd(4'h0, 32'h8006);
		repeat (16) @(posedge core_clk);
		win;
		ck(h, 15);
		ck(q, 3);
		wr(4'h0, 32'h8007);
		win;
		ck(h, 0);
		rd(4'h0, 32'h8017);
		fault_pin <= 0;
		win;
		ck(h, 0);
		rd(4'h0, 32'h8017);
		wr(4'h0, 32'h8017);
		rd(4'h0, 32'h8007);
		repeat (16) @(posedge core_clk);
		win;
		ck(h, 15);
		summarize;
	end
endmodule // occ_output_compare_tb
